//--- logic/motion_sensor_user_offset_trim.sv
`timescale 1ns/1ns
`include "trim_cfg.svh"

// Functional notes
// - Gyro Z trim low byte at 0x7A.
// - Gyro Z trim high nibble, 0x7B bits 3:0.
// - Gyro trim is 1/32 dps per LSB.
// - Accel X trim high nibble, 0x7B bits 7:4.
// - Accel X trim low byte at 0x7C.
// - Accel Y trim low byte at 0x7D.
// - Accel Y trim high nibble, 0x7E bits 3:0.
// - Accel Z trim high nibble, 0x7E bits 7:4.
// - Accel Z trim low byte at 0x7F.
// - Accel trim is 0.5 mg per LSB.
// - All trims read/write, cleared to zero on reset.
// - Gyro X trim: low 0x77, nibble 0x78[3:0].
// - Gyro Y trim: nibble 0x78[7:4], low 0x79.

// User offset trim bank with per-axis correction of the sensor samples.
module motion_sensor_user_offset_trim
   import trim_pkg::*;
#(
   parameter int GYRO_SHIFT  = 0,
   parameter int ACCEL_SHIFT = 0
) (
   input  wire logic     clock,
   input  wire logic     rstn,
   input  wire regReq_t  regReq,
   output      logic [7:0] regRdData,
   output      logic       regRdValid,
   input  wire axisVec_t rawAxes,
   input  wire logic     rawValid,
   output      axisVec_t trimmedAxes,
   output      logic     trimmedValid
);

   bankState_t                 state_reg;    // Register bank and read port state.
   bankState_t                 state_next;   // Next value of the state.
   logic [7:0]                 offset;       // Address relative to the bank base.
   logic                       inBank;       // Address falls inside the bank.
   trimVec_t                   trims;        // Assembled 12-bit trims per axis.
   logic [`TRIM_AXIS_COUNT-1:0] adderValid;  // Output strobes of the adders.

   // Decodes the host access: writes land in the bank, reads return one cycle later.
   always_comb begin
      state_next = state_reg;
      offset     = regReq.addr - `TRIM_ADDR_GYRO_X_LOW;
      inBank     = (regReq.addr >= `TRIM_ADDR_GYRO_X_LOW) && (regReq.addr <= `TRIM_ADDR_ACCEL_Z_LOW);
      state_next.rdValid = regReq.rdStrobe;
      if (regReq.wrStrobe && inBank) begin
         // All nine bytes are plain read/write storage.
         state_next.bank[offset[3:0]] = regReq.wrData;
      end
      if (regReq.rdStrobe) begin
         if (inBank) begin
            state_next.rdData = state_reg.bank[offset[3:0]];
         end else begin
            // Addresses outside the bank read as zero.
            state_next.rdData = `TRIM_UNMAPPED_VALUE;
         end
      end
   end

   // Registers the bank; reset clears every trim byte.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg.bank    <= {`TRIM_REG_COUNT{`TRIM_RESET_VALUE}};
         state_reg.rdData  <= `TRIM_RESET_VALUE;
         state_reg.rdValid <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Assembles each 12-bit trim from its low byte and its shared high nibble.
   always_comb begin
      trims = '0;
      trims[`TRIM_AXIS_GYRO_X] = {
         state_reg.bank[`TRIM_ADDR_GYRO_XY_HIGH - `TRIM_ADDR_GYRO_X_LOW][`TRIM_NIB_LO_MSB:`TRIM_NIB_LO_LSB],
         state_reg.bank[`TRIM_ADDR_GYRO_X_LOW - `TRIM_ADDR_GYRO_X_LOW][`TRIM_LOW_MSB:`TRIM_LOW_LSB]};
      trims[`TRIM_AXIS_GYRO_Y] = {
         state_reg.bank[`TRIM_ADDR_GYRO_XY_HIGH - `TRIM_ADDR_GYRO_X_LOW][`TRIM_NIB_HI_MSB:`TRIM_NIB_HI_LSB],
         state_reg.bank[`TRIM_ADDR_GYRO_Y_LOW - `TRIM_ADDR_GYRO_X_LOW][`TRIM_LOW_MSB:`TRIM_LOW_LSB]};
      trims[`TRIM_AXIS_GYRO_Z] = {
         state_reg.bank[`TRIM_ADDR_GYRO_Z_ACCX_HIGH - `TRIM_ADDR_GYRO_X_LOW][`TRIM_NIB_LO_MSB:`TRIM_NIB_LO_LSB],
         state_reg.bank[`TRIM_ADDR_GYRO_Z_LOW - `TRIM_ADDR_GYRO_X_LOW][`TRIM_LOW_MSB:`TRIM_LOW_LSB]};
      trims[`TRIM_AXIS_ACCEL_X] = {
         state_reg.bank[`TRIM_ADDR_GYRO_Z_ACCX_HIGH - `TRIM_ADDR_GYRO_X_LOW][`TRIM_NIB_HI_MSB:`TRIM_NIB_HI_LSB],
         state_reg.bank[`TRIM_ADDR_ACCEL_X_LOW - `TRIM_ADDR_GYRO_X_LOW][`TRIM_LOW_MSB:`TRIM_LOW_LSB]};
      trims[`TRIM_AXIS_ACCEL_Y] = {
         state_reg.bank[`TRIM_ADDR_ACCEL_YZ_HIGH - `TRIM_ADDR_GYRO_X_LOW][`TRIM_NIB_LO_MSB:`TRIM_NIB_LO_LSB],
         state_reg.bank[`TRIM_ADDR_ACCEL_Y_LOW - `TRIM_ADDR_GYRO_X_LOW][`TRIM_LOW_MSB:`TRIM_LOW_LSB]};
      trims[`TRIM_AXIS_ACCEL_Z] = {
         state_reg.bank[`TRIM_ADDR_ACCEL_YZ_HIGH - `TRIM_ADDR_GYRO_X_LOW][`TRIM_NIB_HI_MSB:`TRIM_NIB_HI_LSB],
         state_reg.bank[`TRIM_ADDR_ACCEL_Z_LOW - `TRIM_ADDR_GYRO_X_LOW][`TRIM_LOW_MSB:`TRIM_LOW_LSB]};
   end

   // One adder per axis; gyro and accel differ only in how the trim LSB maps to the sample LSB.
   for (genvar i = 0; i < `TRIM_AXIS_COUNT; i++) begin : g_axis
      trim_adder #(
         .SHIFT    ((i < `TRIM_AXIS_ACCEL_X) ? GYRO_SHIFT : ACCEL_SHIFT)
      ) u_adder (
         .clock    (clock),
         .rstn     (rstn),
         .rawIn    (rawAxes[i]),
         .trimIn   (trims[i]),
         .validIn  (rawValid),
         .sumOut   (trimmedAxes[i]),
         .validOut (adderValid[i])
      );
   end

   assign trimmedValid = adderValid[0];
   assign regRdData    = state_reg.rdData;
   assign regRdValid   = state_reg.rdValid;

endmodule : motion_sensor_user_offset_trim

//--- logic/trim_adder.sv
`timescale 1ns/1ns
`include "trim_cfg.svh"

// Adds one signed trim value to one axis sample, with saturation.
module trim_adder
   import trim_pkg::*;
#(
   parameter int SHIFT = 0
) (
   input  wire logic                        clock,
   input  wire logic                        rstn,
   input  wire logic [`TRIM_AXIS_WIDTH-1:0] rawIn,
   input  wire logic [`TRIM_WIDTH-1:0]      trimIn,
   input  wire logic                        validIn,
   output      logic [`TRIM_AXIS_WIDTH-1:0] sumOut,
   output      logic                        validOut
);

   localparam int EW = `TRIM_AXIS_WIDTH + 2;  // Sum width with headroom.

   adderState_t             state_reg;        // Registered sum and strobe.
   adderState_t             state_next;       // Next value of the state.
   logic signed [EW-1:0]    extRaw;           // Sign-extended sample.
   logic signed [EW-1:0]    extTrim;          // Sign-extended, scaled trim.
   logic signed [EW-1:0]    wide;             // Unsaturated sum.
   logic signed [EW-1:0]    maxVal;           // Largest sample value.
   logic signed [EW-1:0]    minVal;           // Smallest sample value.

   // The trim is two's complement; the sum clips so a large trim cannot wrap the sample.
   always_comb begin
      state_next = state_reg;
      extRaw     = EW'($signed(rawIn));
      extTrim    = EW'($signed(trimIn)) <<< SHIFT;
      wide       = extRaw + extTrim;
      maxVal     = EW'($signed({1'b0, {(`TRIM_AXIS_WIDTH-1){1'b1}}}));
      minVal     = EW'($signed({1'b1, {(`TRIM_AXIS_WIDTH-1){1'b0}}}));
      state_next.valid = validIn;
      if (validIn) begin
         if (wide > maxVal) begin
            state_next.sum = maxVal[`TRIM_AXIS_WIDTH-1:0];
         end else if (wide < minVal) begin
            state_next.sum = minVal[`TRIM_AXIS_WIDTH-1:0];
         end else begin
            state_next.sum = wide[`TRIM_AXIS_WIDTH-1:0];
         end
      end
   end

   // Registers the adder state.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sumOut   = state_reg.sum;
   assign validOut = state_reg.valid;

endmodule : trim_adder

//--- logic/trim_cfg.svh
`ifndef TRIM_CFG_SVH
`define TRIM_CFG_SVH

// Register addresses of the user offset trim bank.
`define TRIM_ADDR_GYRO_X_LOW       8'h77
`define TRIM_ADDR_GYRO_XY_HIGH     8'h78
`define TRIM_ADDR_GYRO_Y_LOW       8'h79
`define TRIM_ADDR_GYRO_Z_LOW       8'h7A
`define TRIM_ADDR_GYRO_Z_ACCX_HIGH 8'h7B
`define TRIM_ADDR_ACCEL_X_LOW      8'h7C
`define TRIM_ADDR_ACCEL_Y_LOW      8'h7D
`define TRIM_ADDR_ACCEL_YZ_HIGH    8'h7E
`define TRIM_ADDR_ACCEL_Z_LOW      8'h7F

// Number of byte registers in the bank, first to last address.
`define TRIM_REG_COUNT             9

// Every trim register clears to this value.
`define TRIM_RESET_VALUE           8'h00

// Value returned for an address outside the bank.
`define TRIM_UNMAPPED_VALUE        8'h00

// Field positions: a low byte, a low nibble and a high nibble.
`define TRIM_LOW_MSB               7
`define TRIM_LOW_LSB               0
`define TRIM_NIB_LO_MSB            3
`define TRIM_NIB_LO_LSB            0
`define TRIM_NIB_HI_MSB            7
`define TRIM_NIB_HI_LSB            4

// Width of one assembled trim value and of one axis sample.
`define TRIM_WIDTH                 12
`define TRIM_AXIS_WIDTH            16
`define TRIM_AXIS_COUNT            6

// Axis order inside an axis vector.
`define TRIM_AXIS_GYRO_X           0
`define TRIM_AXIS_GYRO_Y           1
`define TRIM_AXIS_GYRO_Z           2
`define TRIM_AXIS_ACCEL_X          3
`define TRIM_AXIS_ACCEL_Y          4
`define TRIM_AXIS_ACCEL_Z          5

// Trim resolution: gyro 1/32 dps, accel 0.5 mg per LSB, in micro units.
`define TRIM_GYRO_LSB_UDPS         31250
`define TRIM_ACCEL_LSB_UG          500

`endif

//--- logic/trim_pkg.sv
`include "trim_cfg.svh"

package trim_pkg;

   // One register access from the serial host interface.
   typedef struct packed {
      logic                   wrStrobe;
      logic                   rdStrobe;
      logic [7:0]             addr;
      logic [7:0]             wrData;
   } regReq_t;

   // Six axis samples, gyro X/Y/Z then accel X/Y/Z.
   typedef logic [`TRIM_AXIS_COUNT-1:0][`TRIM_AXIS_WIDTH-1:0] axisVec_t;

   // Six assembled trim values in the same order.
   typedef logic [`TRIM_AXIS_COUNT-1:0][`TRIM_WIDTH-1:0] trimVec_t;

   // State of the register bank.
   typedef struct packed {
      logic [`TRIM_REG_COUNT-1:0][7:0] bank;
      logic [7:0]                      rdData;
      logic                            rdValid;
   } bankState_t;

   // State of one trim adder.
   typedef struct packed {
      logic [`TRIM_AXIS_WIDTH-1:0] sum;
      logic                        valid;
   } adderState_t;

endpackage : trim_pkg

//--- tb/host_model.sv
`timescale 1ns/1ns
// Host that reaches the trim bank one byte at a time.
module host_model
   import trim_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [7:0] regRdData,
   output      regReq_t    regReq
);
   // Idle bus at time zero.
   initial regReq = '{1'b0, 1'b0, 8'h00, 8'h00};
   // Writes one byte; a released bus shows inverted values.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      regReq <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   // Writes a byte and reads it back in the very next cycle, with no idle cycle between.
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      regReq <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1;
      q = regRdData;
   endtask : wrrd
   // Reads one byte; the answer stands in the cycle after the taking edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clock);
      regReq <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1;
      q = regRdData;
   endtask : rd
endmodule : host_model

//--- tb/motion_sensor_user_offset_trim_test.sv
`timescale 1ns/1ns
// Self-checking bench for the trim bank.
module motion_sensor_user_offset_trim_test
   import trim_pkg::*;
;
   typedef struct packed {logic [7:0] addr; logic [7:0] data;} rowCase_t;
   logic       clock = 1'b0;   // Bench clock, 50 ns period.
   logic       rstn = 1'b0;    // Active-low reset.
   regReq_t    regReq;         // Driven by the host model.
   logic [7:0] regRdData;      // Read byte.
   logic       regRdValid;     // Read strobe back.
   axisVec_t   rawAxes = '0;   // Samples into the bank.
   logic       rawValid = 1'b0; // Sample strobe.
   axisVec_t   trimmedAxes;    // Corrected samples.
   logic       trimmedValid;   // Corrected strobe.
   logic [7:0] q;              // Last byte read.
   int         nMismatch = 0;  // Mismatches so far.
   int         samplesChecked = 0; // Comparisons so far.
   // One write-read row per register, first to last address.
   rowCase_t rows [9] = '{'{8'h77, 8'h11}, '{8'h78, 8'hF2}, '{8'h79, 8'h33}, '{8'h7A, 8'h34},
      '{8'h7B, 8'hA5}, '{8'h7C, 8'hFF}, '{8'h7D, 8'h80}, '{8'h7E, 8'h7C}, '{8'h7F, 8'h01}};
   motion_sensor_user_offset_trim motion_sensor_user_offset_trim_i (.clock(clock), .rstn(rstn),
      .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .rawAxes(rawAxes),
      .rawValid(rawValid), .trimmedAxes(trimmedAxes), .trimmedValid(trimmedValid));
   host_model host_model_i (.clock(clock), .regRdData(regRdData), .regReq(regReq));
   // Clock generator.
   always #25 clock = ~clock;
   // Compares one result and counts it.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samplesChecked++;
      if (got !== exp) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Expected sample: signed trim added, clipped to the 16-bit range.
   function automatic logic [15:0] expSum(input logic [15:0] raw, input logic [3:0] hi, input logic [7:0] lo);
      int s;
      s = int'($signed(raw)) + int'($signed({hi, lo}));
      if (s > 32767) s = 32767;
      if (s < -32768) s = -32768;
      return 16'(s);
   endfunction : expSum
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // Watchdog against a hung run.
   initial begin
      repeat (2000) @(posedge clock);
      nMismatch++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         host_model_i.wrrd(rows[i].addr, rows[i].data, q);
         chk("byte", {8'h00, rows[i].data}, {8'h00, q});
         chk("rd valid", 16'h0001, {15'h0000, regRdValid});
      end
      $display("test registers done");
      @(posedge clock);
      rawAxes <= '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h8000, 16'h7F00};
      rawValid <= 1'b1;
      @(posedge clock);
      rawValid <= 1'b0;
      #1;
      chk("valid", 16'h0001, {15'h0000, trimmedValid});
      chk("gx", expSum(16'h7F00, rows[1].data[3:0], rows[0].data), trimmedAxes[0]);
      chk("gy", expSum(16'h8000, rows[1].data[7:4], rows[2].data), trimmedAxes[1]);
      chk("gz", expSum(16'h1000, rows[4].data[3:0], rows[3].data), trimmedAxes[2]);
      chk("ax", expSum(16'h1000, rows[4].data[7:4], rows[5].data), trimmedAxes[3]);
      chk("ay", expSum(16'h1000, rows[7].data[3:0], rows[6].data), trimmedAxes[4]);
      chk("az", expSum(16'h1000, rows[7].data[7:4], rows[8].data), trimmedAxes[5]);
      $display("test trims done");
      host_model_i.wr(8'h76, 8'h5A);
      host_model_i.rd(8'h76, q);
      chk("unmapped", 16'h0000, {8'h00, q});
      $display("test unmapped done");
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         host_model_i.rd(rows[i].addr, q);
         chk("reset byte", 16'h0000, {8'h00, q});
      end
      $display("test reset done");
      print_verdict();
   end
endmodule : motion_sensor_user_offset_trim_test

//--- tb/trim_bank_sva.sv
`timescale 1ns/1ns
// Watches the register port and the sample path of the trim bank.
module trim_bank_sva
   import trim_pkg::*;
(
   input wire logic       clock,
   input wire logic       rstn,
   input wire regReq_t    regReq,
   input wire logic [7:0] regRdData,
   input wire logic       regRdValid,
   input wire axisVec_t   rawAxes,
   input wire logic       rawValid,
   input wire axisVec_t   trimmedAxes,
   input wire logic       trimmedValid
);
   // All checks share the one clock and its reset.
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   rd_answer_a: assert property (regReq.rdStrobe |=> regRdValid)
      else $error("read not answered");
   rd_quiet_a: assert property (!regReq.rdStrobe |=> !regRdValid)
      else $error("read answer without request");
   rd_hold_a: assert property (!regReq.rdStrobe |=> $stable(regRdData))
      else $error("read byte changed without read");
   unmapped_zero_a: assert property (regReq.rdStrobe && !(regReq.addr inside {[8'h77:8'h7F]})
      |=> regRdData == 8'h00) else $error("unmapped read not zero");
   wr_rd_a: assert property (regReq.wrStrobe ##1 (regReq.rdStrobe && !regReq.wrStrobe
      && regReq.addr == $past(regReq.addr) && regReq.addr inside {[8'h77:8'h7F]})
      |=> regRdData == $past(regReq.wrData, 2)) else $error("written byte not read back");
   trim_answer_a: assert property (rawValid |=> trimmedValid)
      else $error("sample not answered");
   trim_quiet_a: assert property (!rawValid |=> !trimmedValid)
      else $error("trimmed strobe without sample");
   axes_hold_a: assert property (!rawValid |=> $stable(trimmedAxes))
      else $error("trimmed axes changed without sample");
endmodule : trim_bank_sva
bind motion_sensor_user_offset_trim trim_bank_sva trim_bank_sva_i (.clock(clock), .rstn(rstn),
   .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .rawAxes(rawAxes),
   .rawValid(rawValid), .trimmedAxes(trimmedAxes), .trimmedValid(trimmedValid));
